// >>> include/cpcc_pkg.sv
// package: register map, field layout and reset values of the clock path control
// What this block does
// - power-down field resets to 01b, loop off
// - divider ratio field resets to 010b, divide-by-four
// - divider offers two through six, minimum two
// - bypass bit 0b routes through divider
// - source bit 0b selects external clock input
// - power-down 00b gives normal loop operation
// - staged values apply only on update write 01h
// - polarity bit 0 positive, 1 negative
// - external oscillator mode powers internal oscillator off
// - loop settings registers 10h..1Dh hold loop setup
// - source bit 1b selects internal oscillator
package cpcc_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_LOOP_FIRST = 12'h010;
    localparam logic [11:0] OFF_LOOP_LAST = 12'h01d;
    localparam logic [11:0] OFF_OSC_DIV = 12'h1e0;
    localparam logic [11:0] OFF_ROUTING = 12'h1e1;
    localparam logic [11:0] OFF_UPDATE = 12'h232;
    localparam logic [7:0] UPDATE_CODE = 8'h01;
    localparam int NUM_LOOP_REGS = 14;
    localparam int PWR_LSB = 0;
    localparam int POL_BIT = 7;
    localparam int BYPASS_BIT = 0;
    localparam int SOURCE_BIT = 1;
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_ASYNC_DOWN = 2'h1;
    localparam logic [7:0] RST_LOOP0 = 8'h01;
    localparam logic [7:0] RST_LOOP_OTHER = 8'h00;
    localparam logic [7:0] RST_OSC_DIV = 8'h02;
    localparam logic [7:0] RST_ROUTING = 8'h00;
    localparam logic [2:0] DIV_CODE_MIN = 3'h0;
    localparam logic [2:0] DIV_CODE_MAX = 3'h4;
    localparam logic [2:0] DIV_RATIO_OFFSET = 3'h2;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
    typedef logic [7:0] cpcc_byte_t;
endpackage : cpcc_pkg

// >>> rtl/cpcc_osc_divider.sv
// oscillator divider: one-cycle enable every two to six clocks, held high every clock in bypass
module cpcc_osc_divider (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // control
    input wire logic [2:0] ratioCode,
    input wire logic bypass,
    // output
    output logic divTick
);
    import cpcc_pkg::*;

    logic [2:0] count;
    logic [2:0] next_count;
    logic [2:0] ratio;
    logic [2:0] next_ratio;

    always_comb begin
        next_ratio = ratio;
        // codes beyond four clamp to a ratio of six, so the division never drops below two
        if (ratioCode > DIV_CODE_MAX) begin
            next_ratio = DIV_CODE_MAX + DIV_RATIO_OFFSET;
        end else begin
            next_ratio = ratioCode + DIV_RATIO_OFFSET;
        end
        next_count = count + 3'h1;
        if (count + 3'h1 >= ratio || bypass) begin
            next_count = 3'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count <= 3'h0;
            ratio <= RST_OSC_DIV[2:0] + DIV_RATIO_OFFSET;
        end else begin
            count <= next_count;
            ratio <= next_ratio;
        end
    end

    assign divTick = bypass ? 1'b1 : (count == 3'h0);
endmodule : cpcc_osc_divider

// >>> rtl/cpcc_wb_slave.sv
// classic wishbone slave front end: one-cycle registered ack
module cpcc_wb_slave (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // wishbone
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    output logic wbAck,
    // core strobes
    output logic wrStrobe,
    output logic rdStrobe
);
    import cpcc_pkg::*;

    logic next_wbAck;

    always_comb begin
        next_wbAck = wbCyc && wbStb && !wbAck;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wbAck <= 1'b0;
        end else begin
            wbAck <= next_wbAck;
        end
    end

    assign wrStrobe = wbCyc && wbStb && wbWe && !wbAck;
    assign rdStrobe = wbCyc && wbStb && !wbWe && !wbAck;
endmodule : cpcc_wb_slave

// >>> rtl/cpcc_clock_path_ctrl.sv
// clock path configuration control: staged and active registers, routing
//
// Chosen here: the Wishbone register port.
module cpcc_clock_path_ctrl (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // wishbone
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [cpcc_pkg::ADDR_W-1:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    // clock path controls
    output logic loopPowerDown,
    output logic [1:0] loopPowerMode,
    output logic polarityNegative,
    output logic selectInternalOsc,
    output logic internalOscPowered,
    output logic dividerBypass,
    output logic [2:0] dividerRatioCode,
    output logic prescalerFromExternal,
    output logic [7:0] pumpCurrentSetting,
    output logic distTick,
    output logic updatePulse
);
    import cpcc_pkg::*;

    cpcc_byte_t stLoop [NUM_LOOP_REGS];
    cpcc_byte_t stDiv;
    cpcc_byte_t stRoute;
    cpcc_byte_t acLoop [NUM_LOOP_REGS];
    cpcc_byte_t acDiv;
    cpcc_byte_t acRoute;
    cpcc_byte_t next_stLoop [NUM_LOOP_REGS];
    cpcc_byte_t next_stDiv;
    cpcc_byte_t next_stRoute;
    cpcc_byte_t next_acLoop [NUM_LOOP_REGS];
    cpcc_byte_t next_acDiv;
    cpcc_byte_t next_acRoute;
    logic [31:0] next_wbDatR;
    logic next_updatePulse;
    logic wrStrobe;
    logic rdStrobe;
    logic isUpdate;
    logic [ADDR_W-1:0] loopIdx;
    logic [2:0] tickGap;
    logic [2:0] next_tickGap;

    function automatic logic inLoopRange(input logic [ADDR_W-1:0] a);
        return (a >= OFF_LOOP_FIRST) && (a <= OFF_LOOP_LAST);
    endfunction : inLoopRange

    cpcc_wb_slave u_wb (
        .ref_clk(ref_clk),
        .reset(reset),
        .wbCyc(wbCyc),
        .wbStb(wbStb),
        .wbWe(wbWe),
        .wbAck(wbAck),
        .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe)
    );

    assign loopIdx = wbAdr - OFF_LOOP_FIRST;
    assign isUpdate = wrStrobe && wbSel[0] && (wbAdr == OFF_UPDATE)
        && (wbDatW[7:0] == UPDATE_CODE);

    // staged writes and update transfer
    always_comb begin
        next_stLoop = stLoop;
        next_stDiv = stDiv;
        next_stRoute = stRoute;
        next_acLoop = acLoop;
        next_acDiv = acDiv;
        next_acRoute = acRoute;
        next_updatePulse = isUpdate;
        if (wrStrobe && wbSel[0]) begin
            if (inLoopRange(wbAdr)) begin
                next_stLoop[loopIdx[3:0]] = wbDatW[7:0];
            end else if (wbAdr == OFF_OSC_DIV) begin
                next_stDiv = wbDatW[7:0];
            end else if (wbAdr == OFF_ROUTING) begin
                next_stRoute = wbDatW[7:0];
            end
        end
        // whole staged set becomes active at once
        if (isUpdate) begin
            next_acLoop = stLoop;
            next_acDiv = stDiv;
            next_acRoute = stRoute;
        end
    end

    // read data: staged values read back
    always_comb begin
        next_wbDatR = RD_UNMAPPED;
        if (rdStrobe) begin
            if (inLoopRange(wbAdr)) begin
                next_wbDatR = {24'h00_0000, stLoop[loopIdx[3:0]]};
            end else if (wbAdr == OFF_OSC_DIV) begin
                next_wbDatR = {24'h00_0000, stDiv};
            end else if (wbAdr == OFF_ROUTING) begin
                next_wbDatR = {24'h00_0000, stRoute};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int i = 0; i < NUM_LOOP_REGS; i++) begin
                stLoop[i] <= (i == 0) ? RST_LOOP0 : RST_LOOP_OTHER;
                acLoop[i] <= (i == 0) ? RST_LOOP0 : RST_LOOP_OTHER;
            end
            stDiv <= RST_OSC_DIV;
            acDiv <= RST_OSC_DIV;
            stRoute <= RST_ROUTING;
            acRoute <= RST_ROUTING;
            wbDatR <= RD_UNMAPPED;
            updatePulse <= 1'b0;
        end else begin
            stLoop <= next_stLoop;
            acLoop <= next_acLoop;
            stDiv <= next_stDiv;
            acDiv <= next_acDiv;
            stRoute <= next_stRoute;
            acRoute <= next_acRoute;
            wbDatR <= next_wbDatR;
            updatePulse <= next_updatePulse;
        end
    end

    // decoded controls from the active set
    assign loopPowerMode = acLoop[0][PWR_LSB+1:PWR_LSB];
    assign loopPowerDown = (loopPowerMode != PWR_NORMAL);
    assign polarityNegative = acLoop[0][POL_BIT];
    assign pumpCurrentSetting = acLoop[4];
    assign dividerBypass = acRoute[BYPASS_BIT];
    assign selectInternalOsc = acRoute[SOURCE_BIT];
    assign dividerRatioCode = acDiv[2:0];
    // internal oscillator off whenever the external input is the source
    assign internalOscPowered = selectInternalOsc;
    assign prescalerFromExternal = !selectInternalOsc && !loopPowerDown;

    cpcc_osc_divider u_div (
        .ref_clk(ref_clk),
        .reset(reset),
        .ratioCode(dividerRatioCode),
        .bypass(dividerBypass),
        .divTick(distTick)
    );

    // cycles without a divider tick, saturating, for the slowest-ratio check
    always_comb begin
        next_tickGap = 3'h0;
        if (!distTick && tickGap != 3'h7) begin
            next_tickGap = tickGap + 3'h1;
        end else if (!distTick) begin
            next_tickGap = tickGap;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tickGap <= 3'h0;
        end else begin
            tickGap <= next_tickGap;
        end
    end

    property p_reset_defaults;
        @(posedge ref_clk) $past(reset) |-> loopPowerMode == PWR_ASYNC_DOWN;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("power mode not 01b after reset");
    property p_div_default;
        @(posedge ref_clk) $past(reset)
            |-> dividerRatioCode == RST_OSC_DIV[2:0] && !dividerBypass;
    endproperty
    a_div_default: assert property (p_div_default)
        else $error("divider defaults wrong after reset");
    property p_min_div;
        @(posedge ref_clk) disable iff (reset)
        (distTick && !dividerBypass) |=> !distTick;
    endproperty
    a_min_div: assert property (p_min_div)
        else $error("divider output faster than two");
    property p_hold_until_update;
        @(posedge ref_clk) disable iff (reset)
        !$past(isUpdate) |-> $stable(acRoute) && $stable(acDiv);
    endproperty
    a_hold_until_update: assert property (p_hold_until_update)
        else $error("active value changed without update");
    property p_update_copies;
        @(posedge ref_clk) disable iff (reset)
        isUpdate |=> acRoute == $past(stRoute) && acDiv == $past(stDiv)
            && acLoop[0] == $past(stLoop[0]);
    endproperty
    a_update_copies: assert property (p_update_copies)
        else $error("update did not copy staged set");
    property p_power_normal;
        @(posedge ref_clk) disable iff (reset)
        loopPowerMode == PWR_NORMAL |-> !loopPowerDown;
    endproperty
    a_power_normal: assert property (p_power_normal)
        else $error("loop down with normal mode");
    property p_source;
        @(posedge ref_clk) disable iff (reset)
        selectInternalOsc == acRoute[SOURCE_BIT]
            && internalOscPowered == selectInternalOsc;
    endproperty
    a_source: assert property (p_source)
        else $error("source select mismatch");
    property p_polarity;
        @(posedge ref_clk) disable iff (reset)
        isUpdate |=> polarityNegative == $past(stLoop[0][POL_BIT]);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("polarity not applied on update");
    property p_bypass_tick;
        @(posedge ref_clk) disable iff (reset)
        dividerBypass |-> distTick;
    endproperty
    a_bypass_tick: assert property (p_bypass_tick)
        else $error("bypass not passing clock");
    property p_max_div;
        @(posedge ref_clk) disable iff (reset)
        tickGap <= DIV_CODE_MAX + DIV_RATIO_OFFSET - 3'h1;
    endproperty
    a_max_div: assert property (p_max_div)
        else $error("divider output slower than six");
    property p_ack_next;
        @(posedge ref_clk) disable iff (reset)
        (wbCyc && wbStb && !wbAck) |=> wbAck;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("bus request not acknowledged next cycle");
    property p_ack_once;
        @(posedge ref_clk) disable iff (reset)
        wbAck |=> !wbAck;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("acknowledge held longer than one cycle");
    property p_update_pulse;
        @(posedge ref_clk) disable iff (reset)
        isUpdate |=> updatePulse;
    endproperty
    a_update_pulse: assert property (p_update_pulse)
        else $error("no update pulse after update write");
    property p_no_stray_pulse;
        @(posedge ref_clk) disable iff (reset)
        !isUpdate |=> !updatePulse;
    endproperty
    a_no_stray_pulse: assert property (p_no_stray_pulse)
        else $error("update pulse without update write");
    property p_loop_hold;
        @(posedge ref_clk) disable iff (reset)
        !$past(isUpdate) |-> $stable(pumpCurrentSetting)
            && $stable(loopPowerMode) && $stable(polarityNegative);
    endproperty
    a_loop_hold: assert property (p_loop_hold)
        else $error("active loop setting changed without update");
    property p_pump_copy;
        @(posedge ref_clk) disable iff (reset)
        isUpdate |=> pumpCurrentSetting == $past(stLoop[4]);
    endproperty
    a_pump_copy: assert property (p_pump_copy)
        else $error("pump current not applied on update");
    property p_unmapped_read;
        @(posedge ref_clk) disable iff (reset)
        (rdStrobe && !inLoopRange(wbAdr) && wbAdr != OFF_OSC_DIV
            && wbAdr != OFF_ROUTING) |=> wbDatR == RD_UNMAPPED;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read returned nonzero data");
    property p_stage_write;
        @(posedge ref_clk) disable iff (reset)
        (wrStrobe && wbSel[0] && wbAdr == OFF_ROUTING)
            |=> stRoute == $past(wbDatW[7:0]);
    endproperty
    a_stage_write: assert property (p_stage_write)
        else $error("routing write not staged");
    property p_sel_ignored;
        @(posedge ref_clk) disable iff (reset)
        (wrStrobe && !wbSel[0]) |=> $stable(stDiv) && $stable(stRoute)
            && $stable(stLoop[0]);
    endproperty
    a_sel_ignored: assert property (p_sel_ignored)
        else $error("write with byte lane off changed a register");
    property p_internal_off;
        @(posedge ref_clk) disable iff (reset)
        !selectInternalOsc |-> !internalOscPowered;
    endproperty
    a_internal_off: assert property (p_internal_off)
        else $error("internal oscillator powered with external source");
    property p_prescaler;
        @(posedge ref_clk) disable iff (reset)
        prescalerFromExternal |-> !selectInternalOsc
            && loopPowerMode == PWR_NORMAL;
    endproperty
    a_prescaler: assert property (p_prescaler)
        else $error("prescaler fed externally in wrong mode");
    property p_power_down;
        @(posedge ref_clk) disable iff (reset)
        loopPowerMode == PWR_ASYNC_DOWN |-> loopPowerDown;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("loop running in power-down mode");
endmodule : cpcc_clock_path_ctrl

// >>> verif/cpcc_ext_source.sv
// external clock source model: flags settings that overdrive the path
module cpcc_ext_source #(
    parameter int FREQ_MHZ = 1200,
    parameter bit IS_VCO = 1'b0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // controls seen from the block
    input wire logic selectInternalOsc,
    input wire logic dividerBypass,
    input wire logic loopPowerDown,
    // violation flag
    output logic overLimit
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MAX_IN_MHZ = 2400;
    localparam int MAX_CHAN_MHZ = 1600;
    // the flag latches, so any moment of overdrive is reported at the end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            overLimit <= 1'b0;
        end else begin
            overLimit <= overLimit || (FREQ_MHZ > MAX_IN_MHZ)
                || (!selectInternalOsc && dividerBypass
                    && FREQ_MHZ > MAX_CHAN_MHZ)
                || (IS_VCO && !selectInternalOsc && loopPowerDown);
        end
    end
endmodule : cpcc_ext_source

// >>> verif/clock_path_config_control_tb_top.sv
// testbench: register access, staging, update and divider checks
module clock_path_config_control_tb_top import cpcc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset, wbCyc, wbStb, wbWe, wbAck;
    logic [ADDR_W-1:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatW, wbDatR;
    logic loopPowerDown, polarityNegative, selectInternalOsc;
    logic internalOscPowered, dividerBypass, prescalerFromExternal;
    logic distTick, updatePulse, overLimit, up;
    logic [1:0] loopPowerMode;
    logic [2:0] dividerRatioCode;
    logic [15:0] p;
    cpcc_byte_t pumpCurrentSetting, rd;
    int err_total = 0;
    int compares = 0;

    cpcc_clock_path_ctrl i_cpcc_clock_path_ctrl (.ref_clk, .reset, .wbCyc,
        .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW, .wbDatR, .wbAck,
        .loopPowerDown, .loopPowerMode, .polarityNegative, .selectInternalOsc,
        .internalOscPowered, .dividerBypass, .dividerRatioCode,
        .prescalerFromExternal, .pumpCurrentSetting, .distTick, .updatePulse);
    cpcc_ext_source #(.FREQ_MHZ(2000)) i_cpcc_ext_source (.ref_clk, .reset,
        .selectInternalOsc, .dividerBypass, .loopPowerDown, .overLimit);

    task automatic complete_run();
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [23:0] exp,
                         input logic [23:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one classic wishbone cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [11:0] adr,
                      input cpcc_byte_t dat);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= {24'h00_0000, dat};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
        end
        rd = wbDatR[7:0];
        up = updatePulse;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge ref_clk);
    endtask : wb

    task automatic rdchk(input logic [11:0] adr, input cpcc_byte_t exp);
        wb(1'b0, adr, 8'h00);
        check($sformatf("register %h", adr), {16'h0000, exp}, {16'h0000, rd});
    endtask : rdchk

    function automatic logic [23:0] outs();
        return {pumpCurrentSetting, polarityNegative, selectInternalOsc,
                internalOscPowered, dividerBypass, loopPowerDown,
                prescalerFromExternal, loopPowerMode, 5'h00,
                dividerRatioCode};
    endfunction : outs

    // expected outputs derived from the active field values
    function automatic logic [23:0] expo(input logic [1:0] mode,
        input logic pol, input logic sel, input logic byp,
        input logic [2:0] code, input cpcc_byte_t pump);
        return {pump, pol, sel, sel, byp, mode != 2'h0,
                !sel && mode == 2'h0, mode, 5'h00, code};
    endfunction : expo

    // cycles from one divider tick to the next
    task automatic period(output logic [15:0] cnt);
        int n;
        n = 0;
        while (distTick !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        cnt = 16'h0000;
        do begin
            @(posedge ref_clk);
            cnt++;
        end while (distTick !== 1'b1 && cnt < 20);
    endtask : period

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        #200000;
        err_total++;
        complete_run();
    end

    initial begin
        reset = 1'b1;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = '0;
        wbSel = 4'hf;
        wbDatW = 32'h0000_0000;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        check("reset outputs", expo(2'h1, 0, 0, 0, 3'h2, 8'h00), outs());
        rdchk(12'h010, 8'h01);
        rdchk(12'h1e0, 8'h02);
        rdchk(12'h1e1, 8'h00);
        rdchk(12'h014, 8'h00);
        wbSel <= 4'he;
        wb(1'b1, 12'h1e0, 8'h07);
        wbSel <= 4'hf;
        rdchk(12'h1e0, 8'h02);
        wb(1'b1, 12'h100, 8'hff);
        rdchk(12'h100, 8'h00);
        wb(1'b1, 12'h010, 8'h80);
        wb(1'b1, 12'h1e1, 8'h03);
        wb(1'b1, 12'h1e0, 8'h00);
        wb(1'b1, 12'h014, 8'h5a);
        wb(1'b1, 12'h232, 8'h02);
        check("update pulse", 24'h00_0000, {23'h00_0000, up});
        check("staged outputs", expo(2'h1, 0, 0, 0, 3'h2, 8'h00), outs());
        rdchk(12'h014, 8'h5a);
        wb(1'b1, 12'h232, 8'h01);
        check("update pulse", 24'h00_0001, {23'h00_0000, up});
        check("updated outputs", expo(2'h0, 1, 1, 1, 3'h0, 8'h5a), outs());
        period(p);
        check("bypass period", 24'h00_0001, {8'h00, p});
        wb(1'b1, 12'h1e1, 8'h00);
        wb(1'b1, 12'h232, 8'h01);
        check("external loop", expo(2'h0, 1, 0, 0, 3'h0, 8'h5a), outs());
        for (int c = 0; c < 5; c++) begin
            wb(1'b1, 12'h1e0, 8'(c));
            wb(1'b1, 12'h232, 8'h01);
            period(p);
            check("ratio period", 24'(c + 2), {8'h00, p});
        end
        check("source limits", 24'h00_0000, {23'h00_0000, overLimit});
        complete_run();
    end
endmodule : clock_path_config_control_tb_top
